// [src/mdcr_config_regs.sv]
// Purpose: Peripheral and gate-driver configuration words with their decoded settings.
// Assumes: The register port is driven by the serial interface logic on ref_clk.
// Notes: Reads answer one cycle after the read strobe; unmapped reads return zero.
`timescale 1ns/1ps

module mdcr_config_regs
    import mdcr_pkg::*;
#(
    parameter int unsigned OCP_RETRY_CYCLES = OCP_RETRY_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register access port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [31:0] regRdData,
    output logic regRdValid,
    // Rotation direction
    input wire logic dirPin,
    input wire logic motorStopDone,
    output logic rotationCcw,
    output logic motorStopReq,
    output logic isdStartReq,
    output logic reverseDriveReq,
    // Active braking and speed input
    output logic [6:0] brakeSpeedGapPct,
    output logic [6:0] brakeModulationPct,
    output logic [16:0] pwmRefMinHz,
    output logic [16:0] pwmRefMaxHz,
    // Gate driver
    output logic [7:0] slewRateVpus,
    output logic slewRateValid,
    output logic [5:0] overvoltageLevelV,
    output logic overvoltageGuardEnable,
    // Overcurrent
    input wire logic overcurrentPin,
    input wire logic faultClear,
    output logic overcurrentFault
);

    typedef struct packed {
        logic [31:0] periCfg;
        logic [31:0] gdCfg;
        logic [31:0] rdData;
        logic rdValid;
        logic [6:0] gapPct;
        logic [6:0] modPct;
        logic [16:0] pwmMinHz;
        logic [16:0] pwmMaxHz;
        logic [7:0] slewVpus;
        logic slewValid;
        logic [5:0] ovpVolts;
        logic ovpEn;
        logic [1:0] ocpSync;
        logic [7:0] degCnt;
        logic ocpFault;
        logic [31:0] retryCnt;
    } mdcr_regs_t;

    mdcr_regs_t s_reg;
    mdcr_regs_t s_next;
    mdcr_dir_if dirBus();

    logic [7:0] degTarget;
    logic [1:0] ocpMode;
    logic [1:0] slewCode;
    logic ocpAccepted;
    logic [31:0] retryLast;

    assign retryLast = 32'(OCP_RETRY_CYCLES - 1);
    assign degTarget = mdcr_deg_cycles(s_reg.gdCfg[DEG_LSB +: 2]);
    assign ocpMode = s_reg.gdCfg[OCPM_LSB +: 2];
    assign slewCode = s_reg.gdCfg[SLEW_LSB +: 2];
    // The filter counter saturates one below the target, so acceptance holds while high.
    assign ocpAccepted = s_reg.ocpSync[1] && (s_reg.degCnt == degTarget - 8'h01);

    always_comb begin
        s_next = s_reg;
        s_next.rdValid = 1'b0;
        s_next.ocpSync = {s_reg.ocpSync[0], overcurrentPin};

        // Writes only reach implemented bits, parity included.
        if (regWrEn) begin
            if (regAddr == PERI_CFG1_OFFSET) begin
                s_next.periCfg = (s_reg.periCfg & ~PERI_CFG1_MASK)
                    | (regWrData & PERI_CFG1_MASK);
            end else if (regAddr == GD_CFG1_OFFSET) begin
                s_next.gdCfg = (s_reg.gdCfg & ~GD_CFG1_MASK)
                    | (regWrData & GD_CFG1_MASK);
            end
        end

        if (regRdEn) begin
            s_next.rdValid = 1'b1;
            if (regAddr == PERI_CFG1_OFFSET) begin
                s_next.rdData = s_reg.periCfg & PERI_CFG1_MASK;
            end else if (regAddr == GD_CFG1_OFFSET) begin
                s_next.rdData = s_reg.gdCfg & GD_CFG1_MASK;
            end else begin
                s_next.rdData = 32'h00000000;
            end
        end

        s_next.gapPct = mdcr_gap_pct(s_reg.periCfg[GAP_LSB +: 4]);
        s_next.modPct = mdcr_mod_pct(s_reg.periCfg[MODIDX_LSB +: 3]);
        if (s_reg.periCfg[RANGE_BIT]) begin
            s_next.pwmMinHz = PWM_SLOW_MIN_HZ;
            s_next.pwmMaxHz = PWM_SLOW_MAX_HZ;
        end else begin
            s_next.pwmMinHz = PWM_FAST_MIN_HZ;
            s_next.pwmMaxHz = PWM_FAST_MAX_HZ;
        end

        // Reserved slew codes leave the rate at zero and flag it invalid.
        s_next.slewValid = (slewCode == SLEW_CODE_125) || (slewCode == SLEW_CODE_200);
        if (slewCode == SLEW_CODE_200) begin
            s_next.slewVpus = SLEW_VPUS_200;
        end else if (slewCode == SLEW_CODE_125) begin
            s_next.slewVpus = SLEW_VPUS_125;
        end else begin
            s_next.slewVpus = 8'h00;
        end
        s_next.ovpVolts = s_reg.gdCfg[OVERVOLTAGE_THRESHOLD_SELECT_BIT] ? OVP_LOW_V : OVP_HIGH_V;
        s_next.ovpEn = s_reg.gdCfg[OVERVOLTAGE_GUARD_ENABLE_BIT];

        if (!s_reg.ocpSync[1]) begin
            s_next.degCnt = 8'h00;
        end else if (s_reg.degCnt < degTarget - 8'h01) begin
            s_next.degCnt = s_reg.degCnt + 8'h01;
        end

        // A new detection wins over a clear in the same cycle and restarts the retry wait.
        if (ocpAccepted) begin
            s_next.ocpFault = 1'b1;
            s_next.retryCnt = 32'h00000000;
        end else if (s_reg.ocpFault) begin
            if (ocpMode == OCPM_RETRY) begin
                if (s_reg.retryCnt == retryLast) begin
                    s_next.ocpFault = 1'b0;
                end else begin
                    s_next.retryCnt = s_reg.retryCnt + 32'h00000001;
                end
            end else if (faultClear) begin
                // Latch mode, and the reserved codes, wait for software.
                s_next.ocpFault = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.periCfg <= PERI_CFG1_RESET;
            s_reg.gdCfg <= GD_CFG1_RESET;
            s_reg.gapPct <= mdcr_gap_pct(PERI_CFG1_RESET[GAP_LSB +: 4]);
            s_reg.modPct <= mdcr_mod_pct(PERI_CFG1_RESET[MODIDX_LSB +: 3]);
            s_reg.pwmMinHz <= PWM_FAST_MIN_HZ;
            s_reg.pwmMaxHz <= PWM_FAST_MAX_HZ;
            s_reg.ovpVolts <= OVP_HIGH_V;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dirBus.dirSource = s_reg.periCfg[DIR_SRC_LSB +: 2];
    assign dirBus.changeMode = s_reg.periCfg[DIR_MODE_BIT];
    assign dirBus.dirPin = dirPin;
    assign dirBus.stopDone = motorStopDone;

    mdcr_dir_ctrl dirCtrl (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .bus(dirBus.ctrl)
    );

    assign regRdData = s_reg.rdData;
    assign regRdValid = s_reg.rdValid;
    assign rotationCcw = dirBus.rotCcw;
    assign motorStopReq = dirBus.stopReq;
    assign isdStartReq = dirBus.isdReq;
    assign reverseDriveReq = dirBus.reverseReq;
    assign brakeSpeedGapPct = s_reg.gapPct;
    assign brakeModulationPct = s_reg.modPct;
    assign pwmRefMinHz = s_reg.pwmMinHz;
    assign pwmRefMaxHz = s_reg.pwmMaxHz;
    assign slewRateVpus = s_reg.slewVpus;
    assign slewRateValid = s_reg.slewValid;
    assign overvoltageLevelV = s_reg.ovpVolts;
    assign overvoltageGuardEnable = s_reg.ovpEn;
    assign overcurrentFault = s_reg.ocpFault;

    default clocking mcb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence seqGapFine;
        s_reg.periCfg[GAP_LSB +: 4] == 4'hA;
    endsequence

    sequence seqGapCoarse;
        s_reg.periCfg[GAP_LSB +: 4] == 4'hB;
    endsequence

    a_gap_fine: assert property (seqGapFine |=> brakeSpeedGapPct == 7'h32)
        else $error("speed gap code Ah not 50 percent");
    a_gap_coarse: assert property (seqGapCoarse |=> brakeSpeedGapPct == 7'h3C)
        else $error("speed gap code Bh not 60 percent");
    a_mod_decode: assert property (
        (s_reg.periCfg[MODIDX_LSB +: 3] == 3'h1) |=> brakeModulationPct == 7'h28)
        else $error("modulation code 1h not 40 percent");
    a_speed_range: assert property (
        s_reg.periCfg[RANGE_BIT] |=> pwmRefMinHz == 17'h0000A && pwmRefMaxHz == 17'h00145)
        else $error("slow speed range not selected");
    a_slew_reserved: assert property (
        (slewCode < SLEW_CODE_125) |=> !slewRateValid && slewRateVpus == 8'h00)
        else $error("reserved slew code gave a rate");
    a_ovp_level: assert property (
        s_reg.gdCfg[OVERVOLTAGE_THRESHOLD_SELECT_BIT] |=> overvoltageLevelV == 6'h16)
        else $error("overvoltage level not 22 V");
    a_ovp_enable: assert property (
        $rose(s_reg.gdCfg[OVERVOLTAGE_GUARD_ENABLE_BIT]) |=> overvoltageGuardEnable)
        else $error("overvoltage guard not enabled");
    a_filter_time: assert property (
        $rose(overcurrentFault) |-> $past(s_reg.degCnt) == $past(degTarget) - 8'h01
            && $past(s_reg.ocpSync[1]))
        else $error("overcurrent accepted before the filter time");
    a_retry_wait: assert property (
        $fell(overcurrentFault) |-> $past(faultClear) && $past(ocpMode) != OCPM_RETRY
            || $past(s_reg.retryCnt) == retryLast && $past(ocpMode) == OCPM_RETRY)
        else $error("overcurrent fault released early");
    a_reserved_zero: assert property (
        regRdValid |-> (regRdData & ~(PERI_CFG1_MASK | GD_CFG1_MASK)) == 32'h00000000)
        else $error("reserved bits read non-zero");

    sequence seqGdWrite;
        regWrEn && regAddr == GD_CFG1_OFFSET;
    endsequence

    sequence seqPeriWrite;
        regWrEn && regAddr == PERI_CFG1_OFFSET;
    endsequence

    sequence seqFaultHeld;
        s_reg.ocpFault && ocpMode != OCPM_RETRY && !faultClear;
    endsequence

    sequence seqRetryPending;
        s_reg.ocpFault && ocpMode == OCPM_RETRY && s_reg.retryCnt != retryLast;
    endsequence

    a_gap_reserved: assert property (
        (s_reg.periCfg[GAP_LSB +: 4] == 4'h0) |=> brakeSpeedGapPct == 7'h00)
        else $error("speed gap code 0h not zero");
    a_mod_zero: assert property (
        (s_reg.periCfg[MODIDX_LSB +: 3] == 3'h0) |=> brakeModulationPct == 7'h00)
        else $error("modulation code 0h not zero");
    a_fast_range: assert property (
        !s_reg.periCfg[RANGE_BIT] |=> pwmRefMinHz == 17'h00145 && pwmRefMaxHz == 17'h186A0)
        else $error("fast speed range not selected");
    a_slew_fast: assert property (
        (slewCode == SLEW_CODE_200) |=> slewRateValid && slewRateVpus == 8'hC8)
        else $error("slew code 3h not 200");
    a_ovp_high: assert property (
        !s_reg.gdCfg[OVERVOLTAGE_THRESHOLD_SELECT_BIT] |=> overvoltageLevelV == 6'h22)
        else $error("overvoltage level not 34 V");
    a_ovp_disable: assert property (
        !s_reg.gdCfg[OVERVOLTAGE_GUARD_ENABLE_BIT] |=> !overvoltageGuardEnable)
        else $error("overvoltage guard not disabled");
    a_write_lands: assert property (
        seqGdWrite |=> (s_reg.gdCfg & GD_CFG1_MASK) == ($past(regWrData) & GD_CFG1_MASK))
        else $error("gate-driver write lost");
    a_reserved_kept: assert property (
        seqPeriWrite |=> (s_reg.periCfg & ~PERI_CFG1_MASK)
            == ($past(s_reg.periCfg) & ~PERI_CFG1_MASK))
        else $error("reserved peripheral bits changed");
    a_fault_latched: assert property (seqFaultHeld |=> overcurrentFault)
        else $error("latched overcurrent fault released");
    a_retry_hold: assert property (seqRetryPending |=> overcurrentFault)
        else $error("retrying fault released early");
    a_unmapped_zero: assert property (
        (regRdEn && regAddr != PERI_CFG1_OFFSET && regAddr != GD_CFG1_OFFSET)
            |=> regRdValid && regRdData == 32'h00000000)
        else $error("unmapped read not zero");
    a_read_valid: assert property (regRdEn |=> regRdValid)
        else $error("read not answered");

endmodule

// [src/mdcr_dir_ctrl.sv]
// Purpose: Picks the rotation sense and sequences the reaction to a sense change.
// Assumes: stopDone is a same-clock level or pulse from the motor stop logic.
// Notes: rotCcw low means phase order A-B-C, high means A-C-B.
`timescale 1ns/1ps
module mdcr_dir_ctrl
    import mdcr_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Direction handshake
    mdcr_dir_if.ctrl bus
);

    typedef struct packed {
        logic [1:0] pinSync;
        mdcr_dir_state_t state;
        logic rotCcw;
        logic stopReq;
        logic isdReq;
        logic reverseReq;
    } mdcr_dir_regs_t;

    mdcr_dir_regs_t s_reg;
    mdcr_dir_regs_t s_next;
    logic wantCcw;

    always_comb begin
        if (bus.dirSource == DIR_SRC_CW) begin
            wantCcw = 1'b0;
        end else if (bus.dirSource == DIR_SRC_CCW) begin
            wantCcw = 1'b1;
        end else begin
            wantCcw = s_reg.pinSync[1];
        end
    end

    always_comb begin
        s_next = s_reg;
        s_next.pinSync = {s_reg.pinSync[0], bus.dirPin};
        s_next.stopReq = 1'b0;
        s_next.isdReq = 1'b0;
        s_next.reverseReq = 1'b0;
        unique case (s_reg.state)
            DIR_IDLE: begin
                if (wantCcw != s_reg.rotCcw) begin
                    if (bus.changeMode) begin
                        // Reverse while driving; the motor is never stopped.
                        s_next.rotCcw = wantCcw;
                        s_next.reverseReq = 1'b1;
                    end else begin
                        s_next.stopReq = 1'b1;
                        s_next.state = DIR_WAIT_STOP;
                    end
                end
            end
            DIR_WAIT_STOP: begin
                if (bus.stopDone) begin
                    s_next.state = DIR_START_ISD;
                end
            end
            DIR_START_ISD: begin
                // The sense is sampled again here, so a change during the stop is kept.
                s_next.rotCcw = wantCcw;
                s_next.isdReq = 1'b1;
                s_next.state = DIR_IDLE;
            end
            default: begin
                s_next.state = DIR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{pinSync: 2'h0, state: DIR_IDLE, rotCcw: 1'b0,
                       stopReq: 1'b0, isdReq: 1'b0, reverseReq: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.rotCcw = s_reg.rotCcw;
    assign bus.stopReq = s_reg.stopReq;
    assign bus.isdReq = s_reg.isdReq;
    assign bus.reverseReq = s_reg.reverseReq;

    default clocking dcb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence seqChangeStop;
        s_reg.state == DIR_IDLE && wantCcw != s_reg.rotCcw && !bus.changeMode;
    endsequence

    sequence seqStopReleased;
        s_reg.state == DIR_WAIT_STOP && bus.stopDone;
    endsequence

    a_override_cw: assert property (
        (bus.dirSource == DIR_SRC_CW && s_reg.state == DIR_IDLE && bus.changeMode)
            |=> !s_reg.rotCcw)
        else $error("clockwise override not applied");
    a_override_ccw: assert property (
        (bus.dirSource == DIR_SRC_CCW && s_reg.state == DIR_IDLE && bus.changeMode)
            |=> s_reg.rotCcw)
        else $error("counter-clockwise override not applied");
    a_pin_source: assert property (
        ((bus.dirSource == 2'h0 || bus.dirSource == 2'h3) && s_reg.state == DIR_IDLE
            && bus.changeMode) |=> s_reg.rotCcw == $past(s_reg.pinSync[1]))
        else $error("rotation sense does not follow the pin");
    a_stop_first: assert property (
        seqChangeStop |=> s_reg.stopReq && !s_reg.isdReq && !s_reg.reverseReq)
        else $error("sense change did not request a stop first");
    a_isd_after_stop: assert property (
        seqStopReleased |=> !s_reg.isdReq ##1 s_reg.isdReq && s_reg.state == DIR_IDLE)
        else $error("speed detection did not follow the stop");
    a_reverse_drive: assert property (
        (s_reg.state == DIR_IDLE && wantCcw != s_reg.rotCcw && bus.changeMode)
            |=> s_reg.reverseReq && !s_reg.stopReq && s_reg.rotCcw == $past(wantCcw))
        else $error("reverse drive not taken or motor stopped");

endmodule

// [src/mdcr_dir_if.sv]
// Purpose: Carries direction settings and the stop, detect and reverse handshake.
// Assumes: All signals are on ref_clk except dirPin, which is a raw pin.
// Notes: The cfg side is the register file, the ctrl side the direction sequencer.
`timescale 1ns/1ps
interface mdcr_dir_if;
    logic [1:0] dirSource;
    logic changeMode;
    logic dirPin;
    logic stopDone;
    logic rotCcw;
    logic stopReq;
    logic isdReq;
    logic reverseReq;

    modport cfg (
        output dirSource, changeMode, dirPin, stopDone,
        input rotCcw, stopReq, isdReq, reverseReq
    );
    modport ctrl (
        input dirSource, changeMode, dirPin, stopDone,
        output rotCcw, stopReq, isdReq, reverseReq
    );
endinterface

// [src/mdcr_pkg.sv]
// Purpose: Shared constants for the motor drive configuration register block.
// Assumes: 100 MHz reference clock; register offsets are byte-free indices as printed.
// Notes: Percent, volt and hertz decodes are plain binary values.
package mdcr_pkg;

    // Register map.
    localparam logic [7:0] PERI_CFG1_OFFSET = 8'hAA;
    localparam logic [7:0] GD_CFG1_OFFSET = 8'hAC;
    localparam logic [31:0] PERI_CFG1_RESET = 32'h40000000;
    localparam logic [31:0] GD_CFG1_RESET = 32'h10228100;
    // Writable, and therefore readable, bits; all others read as zero.
    localparam logic [31:0] PERI_CFG1_MASK = 32'h43FDFE00;
    localparam logic [31:0] GD_CFG1_MASK = 32'h8C0C3703;

    // Peripheral word field positions.
    localparam int DIR_SRC_LSB = 19;
    localparam int DIR_MODE_BIT = 18;
    localparam int GAP_LSB = 13;
    localparam int MODIDX_LSB = 10;
    localparam int RANGE_BIT = 9;

    // Gate-driver word field positions.
    localparam int PARITY_BIT = 31;
    localparam int SLEW_LSB = 26;
    localparam int OVERVOLTAGE_THRESHOLD_SELECT_BIT = 19;
    localparam int OVERVOLTAGE_GUARD_ENABLE_BIT = 18;
    localparam int DEG_LSB = 12;
    localparam int OCPM_LSB = 8;

    // Field codes.
    localparam logic [1:0] DIR_SRC_CW = 2'h1;
    localparam logic [1:0] DIR_SRC_CCW = 2'h2;
    localparam logic [1:0] SLEW_CODE_125 = 2'h2;
    localparam logic [1:0] SLEW_CODE_200 = 2'h3;
    localparam logic [1:0] OCPM_LATCH = 2'h0;
    localparam logic [1:0] OCPM_RETRY = 2'h1;
    localparam logic [3:0] GAP_FINE_LAST = 4'hA;

    // Decoded values.
    localparam logic [7:0] SLEW_VPUS_125 = 8'h7D;
    localparam logic [7:0] SLEW_VPUS_200 = 8'hC8;
    localparam logic [5:0] OVP_HIGH_V = 6'h22;
    localparam logic [5:0] OVP_LOW_V = 6'h16;
    localparam logic [16:0] PWM_FAST_MIN_HZ = 17'h00145;
    localparam logic [16:0] PWM_FAST_MAX_HZ = 17'h186A0;
    localparam logic [16:0] PWM_SLOW_MIN_HZ = 17'h0000A;
    localparam logic [16:0] PWM_SLOW_MAX_HZ = 17'h00145;
    localparam int GAP_FINE_STEP = 5;
    localparam int GAP_COARSE_STEP = 10;
    localparam int GAP_COARSE_BASE = 50;
    localparam int MODIDX_STEP = 10;
    localparam int MODIDX_BASE = 30;

    // Timing.
    localparam int CLK_FREQ_MHZ = 100;
    localparam int DEG0_NS = 200;
    localparam int DEG1_NS = 600;
    localparam int DEG2_NS = 1200;
    localparam int DEG3_NS = 1600;
    localparam int DEG0_CYC = (DEG0_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int DEG1_CYC = (DEG1_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int DEG2_CYC = (DEG2_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int DEG3_CYC = (DEG3_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int OCP_RETRY_MS = 500;
    localparam int OCP_RETRY_CYC = OCP_RETRY_MS * CLK_FREQ_MHZ * 1000;

    // States of the direction change sequencer; every step except the return to idle flips one bit.
    typedef enum logic [1:0] {
        DIR_IDLE = 2'h0,
        DIR_WAIT_STOP = 2'h1,
        DIR_START_ISD = 2'h3
    } mdcr_dir_state_t;

    function automatic logic [6:0] mdcr_gap_pct(input logic [3:0] code);
        if (code == 4'h0) begin
            return 7'h00;
        end else if (code <= GAP_FINE_LAST) begin
            return 7'(int'(code) * GAP_FINE_STEP);
        end else begin
            return 7'((int'(code) - int'(GAP_FINE_LAST)) * GAP_COARSE_STEP + GAP_COARSE_BASE);
        end
    endfunction

    function automatic logic [6:0] mdcr_mod_pct(input logic [2:0] code);
        if (code == 3'h0) begin
            return 7'h00;
        end else begin
            return 7'((int'(code) * MODIDX_STEP) + MODIDX_BASE);
        end
    endfunction

    function automatic logic [7:0] mdcr_deg_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: return 8'(DEG0_CYC);
            2'h1: return 8'(DEG1_CYC);
            2'h2: return 8'(DEG2_CYC);
            2'h3: return 8'(DEG3_CYC);
        endcase
    endfunction

endpackage

// [verification/mdcr_config_regs_test.sv]
// Purpose: Self-checking bench for the motor drive configuration registers.
// Assumes: Retry count shortened to 50 cycles; tests take about 800 cycles.
// Notes: Motor stop logic is mimicked here with a fixed six-cycle delay.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module mdcr_config_regs_test;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr;
    logic [31:0] regWrData, regRdData, d;
    logic regWrEn, regRdEn, regRdValid, rotationCcw, motorStopReq, isdStartReq;
    logic reverseDriveReq, slewRateValid, overvoltageGuardEnable, overcurrentFault;
    logic dirPin = 1'b0;
    logic motorStopDone = 1'b0;
    logic overcurrentPin = 1'b0;
    logic faultClear = 1'b0;
    logic [6:0] brakeSpeedGapPct, brakeModulationPct;
    logic [16:0] pwmRefMinHz, pwmRefMaxHz;
    logic [7:0] slewRateVpus;
    logic [5:0] overvoltageLevelV;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    int revCnt = 0;
    int stopCnt = 0;
    int isdCnt = 0;
    int stopWait = 0;
    int degN[4] = '{20, 60, 120, 160};

    mdcr_config_regs #(.OCP_RETRY_CYCLES(50)) i_mdcr_config_regs (
        .ref_clk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
        .regRdValid, .dirPin, .motorStopDone, .rotationCcw, .motorStopReq,
        .isdStartReq, .reverseDriveReq, .brakeSpeedGapPct, .brakeModulationPct,
        .pwmRefMinHz, .pwmRefMaxHz, .slewRateVpus, .slewRateValid, .overvoltageLevelV,
        .overvoltageGuardEnable, .overcurrentPin, .faultClear, .overcurrentFault
    );
    mdcr_host_model i_mdcr_host_model (
        .ref_clk, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .regRdValid
    );

    always #5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cycles++;
        if (reverseDriveReq === 1'b1) revCnt++;
        if (motorStopReq === 1'b1) stopCnt++;
        if (isdStartReq === 1'b1) isdCnt++;
        motorStopDone <= (stopWait == 1);
        if (motorStopReq === 1'b1) stopWait <= 6;
        else if (stopWait > 0) stopWait <= stopWait - 1;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        i_mdcr_host_model.wr(a, v);
    endtask
    task automatic rd(input logic [7:0] a);
        i_mdcr_host_model.rd(a, d);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        int g;
        repeat (8) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        settle(1);
        `CHK("pwmMin", 17'h00145, pwmRefMinHz)
        `CHK("pwmMax", 17'h186A0, pwmRefMaxHz)
        `CHK("slewValid", 1'b0, slewRateValid)
        `CHK("ovLevel", 6'h22, overvoltageLevelV)
        `CHK("ovEnable", 1'b0, overvoltageGuardEnable)
        `CHK("gap0", 7'h00, brakeSpeedGapPct)
        `CHK("mod0", 7'h00, brakeModulationPct)
        rd(8'hAA); `CHK("periReset", 32'h40000000, d)
        rd(8'hAC); `CHK("gdReset", 32'h00000100, d)
        rd(8'h10); `CHK("unmapped", 32'h00000000, d)
        done("reset");
        wr(8'hAC, 32'hFFFFFFFF); rd(8'hAC); `CHK("gdMask", 32'h8C0C3703, d)
        wr(8'hAA, 32'hFFFFFFFF); rd(8'hAA); `CHK("periMask", 32'h43FDFE00, d)
        wr(8'hAB, 32'h00000000); rd(8'hAA); `CHK("periKeep", 32'h43FDFE00, d)
        wr(8'hAA, 32'h00000000);
        done("access");
        for (int i = 0; i < 4; i++) begin
            wr(8'hAC, 32'(i) << 26);
            settle(2);
            `CHK("slew", (i == 2) ? 8'h7D : (i == 3) ? 8'hC8 : 8'h00, slewRateVpus)
            `CHK("slewValid", 1'(i >= 2), slewRateValid)
            wr(8'hAC, 32'(i) << 18);
            settle(2);
            `CHK("ovLevel", i[1] ? 6'h16 : 6'h22, overvoltageLevelV)
            `CHK("ovEnable", i[0], overvoltageGuardEnable)
        end
        done("gate");
        for (int c = 1; c < 16; c++) begin
            wr(8'hAA, (32'(c) << 13) | (32'(c & 7) << 10));
            settle(2);
            g = (c <= 10) ? c * 5 : (c - 10) * 10 + 50;
            `CHK("gap", 7'(g), brakeSpeedGapPct)
            g = ((c & 7) == 0) ? 0 : 30 + 10 * (c & 7);
            `CHK("modIdx", 7'(g), brakeModulationPct)
        end
        wr(8'hAA, 32'h00000200);
        settle(2);
        `CHK("pwmMin", 17'h0000A, pwmRefMinHz)
        `CHK("pwmMax", 17'h00145, pwmRefMaxHz)
        done("braking");
        wr(8'hAA, 32'h00140000); settle(6);
        `CHK("rotCcw", 1'b1, rotationCcw)
        `CHK("reverses", 1, revCnt)
        dirPin = 1'b1;
        wr(8'hAA, 32'h000C0000); settle(6);
        `CHK("rotCw", 1'b0, rotationCcw)
        `CHK("stops", 0, stopCnt)
        wr(8'hAA, 32'h00000000); settle(20);
        `CHK("rotPin", 1'b1, rotationCcw)
        `CHK("stops", 1, stopCnt)
        `CHK("detects", 1, isdCnt)
        wr(8'hAA, 32'h00180000); dirPin = 1'b0; settle(20);
        `CHK("rotPin", 1'b0, rotationCcw)
        `CHK("detects", 2, isdCnt)
        `CHK("reverses", 2, revCnt)
        done("direction");
        for (int i = 0; i < 4; i++) begin
            wr(8'hAC, 32'(i) << 12);
            overcurrentPin = 1'b1;
            settle(degN[i]);
            `CHK("ocEarly", 1'b0, overcurrentFault)
            settle(5);
            `CHK("ocLate", 1'b1, overcurrentFault)
            overcurrentPin = 1'b0;
            settle(4);
            `CHK("ocLatched", 1'b1, overcurrentFault)
            faultClear = 1'b1; settle(1); faultClear = 1'b0; settle(1);
            `CHK("ocCleared", 1'b0, overcurrentFault)
        end
        wr(8'hAC, 32'h00000100);
        overcurrentPin = 1'b1; settle(30); overcurrentPin = 1'b0; settle(3);
        faultClear = 1'b1; settle(1); faultClear = 1'b0; settle(20);
        `CHK("ocRetryHold", 1'b1, overcurrentFault)
        settle(40);
        `CHK("ocRetryEnd", 1'b0, overcurrentFault)
        wr(8'hAC, 32'h00000200);
        overcurrentPin = 1'b1; settle(30); overcurrentPin = 1'b0; settle(60);
        `CHK("ocReserved", 1'b1, overcurrentFault)
        faultClear = 1'b1; settle(1); faultClear = 1'b0; settle(1);
        `CHK("ocResCleared", 1'b0, overcurrentFault)
        done("overcurrent");
        report_and_stop();
    end
endmodule

// [verification/mdcr_host_model.sv]
// Purpose: Host side of the register port, issuing single-word writes and reads.
// Assumes: Strobes are one-cycle pulses; read data is valid one cycle after the strobe.
// Notes: Released write data shows the inverse of the last word, never a stale copy.
`timescale 1ns/1ps
module mdcr_host_model (
    // Clock
    input wire logic ref_clk,
    // Register port
    output logic [7:0] regAddr,
    output logic [31:0] regWrData,
    output logic regWrEn,
    output logic regRdEn,
    input wire logic [31:0] regRdData,
    input wire logic regRdValid
);
    initial begin
        regAddr = 8'h00;
        regWrData = 32'h00000000;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        #1;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge ref_clk);
        #1;
        regWrEn = 1'b0;
        regWrData = ~d;
    endtask

    // A missing valid pulse returns unknown so the caller's compare fails.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        #1;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge ref_clk);
        #1;
        regRdEn = 1'b0;
        d = (regRdValid === 1'b1) ? regRdData : 32'hXXXXXXXX;
    endtask
endmodule
